// >>> rtl/dcp_defs.svh
// Offsets, field positions, reset values and codes of the cache policy block.
// Assumes byte addresses on an 8-bit register address port, one word each.
`ifndef DCP_DEFS_SVH
`define DCP_DEFS_SVH

// Register byte offsets
`define DCP_OFS_CTRL 8'h00
`define DCP_OFS_DISLEN 8'h04
`define DCP_OFS_MINPF 8'h08
`define DCP_OFS_MAXPF 8'h0C
`define DCP_OFS_CEIL 8'h10
`define DCP_OFS_LASTLBA 8'h14
`define DCP_OFS_STATUS 8'h18
`define DCP_OFS_FETCHED 8'h1C

// Control register fields
`define DCP_CTRL_WRET_LSB 0
`define DCP_CTRL_RRET_LSB 4
`define DCP_CTRL_SCALE_BIT 8

// Status register fields
`define DCP_ST_DEFERR_BIT 0
`define DCP_ST_BUSY_BIT 1
`define DCP_ST_SUPERR_BIT 2

// Reset values
`define DCP_RST_CODE 4'h0
`define DCP_RST_LEN16 16'h0000
`define DCP_RST_LASTLBA 32'hFFFFFFFF

// Retention priority codes
`define DCP_RET_LOW 4'h1
`define DCP_RET_HIGH 4'hF

// Eviction ranks, lower is evicted first
`define DCP_RANK_EARLY 2'h0
`define DCP_RANK_PLAIN 2'h1
`define DCP_RANK_KEEP 2'h2
`define DCP_RANK_NONE 2'h3

`endif

// >>> rtl/dcp_pkg.sv
// Types shared by the cache policy block and its bench.
// Assumes dcp_defs.svh provides the numeric constants.
package dcp_pkg;
  typedef enum logic [0:0] {DCP_IDLE, DCP_FETCH} dcp_state_t;
endpackage : dcp_pkg

// >>> rtl/dcp_prefetch.sv
// Cache replacement choice and anticipatory pre-fetch sequencing.
// Assumes one clock, a same-clock command decoder, a media engine that
// fetches one block per pf_ack, and a cache that reports its line classes.
// Overview of operation
// - Code zero: treat data like pre-fetched data
// - Read code one: evict read data first
// - Write code one: evict written data first
// - Read code F: keep read data while others
// - Write code F: keep written data while others
// - Pre-fetch advisory, never raises check condition
// - Skip pre-fetch when length exceeds threshold
// - Threshold zero disables every pre-fetch
// - Fetch at least scaled minimum, or capped maximum if lower
// - Start right after previous read's end
// - Stop before passing medium's last block
// - Suppress pre-fetch errors unless fatal, deferred
// - Above minimum, abandon when command waits
// - Minimum equals maximum: never abandon early
// - Fetch scaled maximum when nothing waits
// - Cap computed maximum at ceiling value
// - Scale bit multiplies fields by length
// - Read priority covers delivered read data
`timescale 1ns/100ps
`include "dcp_defs.svh"

module dcp_prefetch #(
  parameter int LINES = 8,
  parameter int IDXW = $clog2(LINES)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic [31:0] cmd_lba,
  input wire logic [15:0] cmd_len,
  input wire logic cmd_pending,
  output logic cmd_ready,
  // Media pre-fetch engine
  output logic pf_req,
  output logic [31:0] pf_lba,
  input wire logic pf_ack,
  input wire logic pf_err,
  input wire logic pf_err_fatal,
  output logic deferred_err,
  output dcp_pkg::dcp_state_t pf_state,
  // Replacement choice
  input wire logic victim_req,
  input wire logic [LINES-1:0] line_evictable,
  input wire logic [LINES-1:0] line_from_read,
  input wire logic [LINES-1:0] line_from_write,
  output logic victim_valid,
  output logic victim_found,
  output logic [IDXW-1:0] victim_idx
);
  import dcp_pkg::*;
  // Software-visible settings
  logic [3:0] wret_reg;
  logic [3:0] rret_reg;
  logic scale_reg;
  logic [15:0] dislen_reg;
  logic [15:0] minpf_reg;
  logic [15:0] maxpf_reg;
  logic [15:0] ceil_reg;
  logic [31:0] lastlba_reg;
  logic superr_reg;
  // Pre-fetch engine state
  dcp_state_t state_reg;
  dcp_state_t state_next;
  logic [31:0] fetched_reg;
  logic [31:0] min_target_reg;
  logic [31:0] max_target_reg;
  logic no_abort_reg;
  // Command evaluation
  logic cmd_take;
  logic pf_allowed;
  logic [31:0] min_scaled;
  logic [31:0] max_scaled;
  logic [31:0] max_capped;
  logic [32:0] start_lba;
  logic start_ok;
  // Fetch progress
  logic fatal_hit;
  logic abort_hit;
  logic [31:0] fetched_inc;
  logic [32:0] lba_inc;
  logic done_hit;
  // Replacement search
  logic [1:0] best_rank;
  logic [IDXW-1:0] best_idx;
  // Rank of a line under the two retention codes; reserved codes act as zero
  function automatic logic [1:0] line_rank(input logic from_rd, input logic from_wr,
                                           input logic [3:0] rcode, input logic [3:0] wcode);
    logic [3:0] code;
    code = from_rd ? rcode : (from_wr ? wcode : `DCP_RST_CODE);
    if (!from_rd && !from_wr)
      line_rank = `DCP_RANK_PLAIN;
    else if (code == `DCP_RET_LOW)
      line_rank = `DCP_RANK_EARLY;
    else if (code == `DCP_RET_HIGH)
      line_rank = `DCP_RANK_KEEP;
    else
      line_rank = `DCP_RANK_PLAIN;
  endfunction : line_rank
  // Command taken; a zero threshold shuts pre-fetch off, even for zero length
  assign cmd_take = cmd_valid && cmd_ready;
  assign pf_allowed = cmd_is_read && (dislen_reg != `DCP_RST_LEN16)
                      && (cmd_len <= dislen_reg);
  // Scaled counts; the product of two 16-bit fields fits 32 bits
  assign min_scaled = scale_reg ? 32'(minpf_reg) * 32'(cmd_len) : 32'(minpf_reg);
  assign max_scaled = scale_reg ? 32'(maxpf_reg) * 32'(cmd_len) : 32'(maxpf_reg);
  assign max_capped = (max_scaled > {16'h0000, ceil_reg}) ? {16'h0000, ceil_reg}
                      : max_scaled;
  // Start after the read's final block; 33 bits so a wrap is not mistaken
  assign start_lba = {1'b0, cmd_lba} + {17'h00000, cmd_len};
  assign start_ok = start_lba <= {1'b0, lastlba_reg};
  // Events during a fetch, in order of precedence
  assign fatal_hit = pf_err && pf_err_fatal;
  assign abort_hit = cmd_pending && !no_abort_reg
                     && (fetched_reg > min_target_reg);
  assign fetched_inc = fetched_reg + 32'h00000001;
  assign lba_inc = {1'b0, pf_lba} + 33'h000000001;
  assign done_hit = (fetched_inc >= max_target_reg)
                    || (lba_inc > {1'b0, lastlba_reg});
  // Next state of the pre-fetch sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      DCP_IDLE:
      begin
        if (cmd_take && pf_allowed && start_ok && (max_capped != 32'h00000000))
          state_next = DCP_FETCH;
      end
      DCP_FETCH:
      begin
        if (fatal_hit)
          state_next = DCP_IDLE;
        else if (abort_hit)
          state_next = DCP_IDLE;
        else if (pf_ack && done_hit)
          state_next = DCP_IDLE;
      end
      default:
        state_next = DCP_IDLE;
    endcase
  end
  // Sequencer state and its visible copy
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= DCP_IDLE;
      pf_state <= DCP_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      pf_state <= state_next;
    end
  end
  // Commands wait while a fetch runs, so the minimum is never cut short
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= (state_next == DCP_IDLE);
  end

  // Targets latched once per READ so fetch size changes do not disturb a fetch
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      min_target_reg <= 32'h00000000;
      max_target_reg <= 32'h00000000;
      no_abort_reg <= 1'b0;
    end
    else if (state_reg == DCP_IDLE && state_next == DCP_FETCH)
    begin
      min_target_reg <= min_scaled;
      max_target_reg <= max_capped;
      no_abort_reg <= (minpf_reg == maxpf_reg);
    end
  end

  // Request, address and block count toward the media engine
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pf_req <= 1'b0;
      pf_lba <= 32'h00000000;
      fetched_reg <= 32'h00000000;
    end
    else if (state_reg == DCP_IDLE && state_next == DCP_FETCH)
    begin
      pf_req <= 1'b1;
      pf_lba <= start_lba[31:0];
      fetched_reg <= 32'h00000000;
    end
    else if (state_reg == DCP_FETCH)
    begin
      pf_req <= (state_next == DCP_FETCH);
      if (state_next == DCP_FETCH && pf_ack)
      begin
        pf_lba <= lba_inc[31:0];
        fetched_reg <= fetched_inc;
      end
      else if (pf_ack && !fatal_hit && !abort_hit)
        fetched_reg <= fetched_inc; // Last block of a completed fetch counts
    end
  end

  // Errors stay hidden unless fatal; then only a deferred flag, never a check condition
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      deferred_err <= 1'b0;
    else if (state_reg == DCP_FETCH && fatal_hit)
      deferred_err <= 1'b1;
    else if (reg_wr && reg_addr == `DCP_OFS_STATUS && reg_wdata[`DCP_ST_DEFERR_BIT])
      deferred_err <= 1'b0;
  end

  // Suppressed error seen; set wins over a same-cycle clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      superr_reg <= 1'b0;
    else if (state_reg == DCP_FETCH && pf_err && !pf_err_fatal)
      superr_reg <= 1'b1;
    else if (reg_wr && reg_addr == `DCP_OFS_STATUS && reg_wdata[`DCP_ST_SUPERR_BIT])
      superr_reg <= 1'b0;
  end

  // Best victim: lowest rank among evictable lines, lowest index on a tie
  always_comb
  begin
    best_rank = `DCP_RANK_NONE;
    best_idx = '0;
    for (int i = 0; i < LINES; i++)
    begin
      if (line_evictable[i]
          && line_rank(line_from_read[i], line_from_write[i], rret_reg, wret_reg) < best_rank)
      begin
        best_rank = line_rank(line_from_read[i], line_from_write[i], rret_reg, wret_reg);
        best_idx = IDXW'(i);
      end
    end
  end

  // Victim answer one cycle after the request
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      victim_valid <= 1'b0;
      victim_found <= 1'b0;
      victim_idx <= '0;
    end
    else
    begin
      victim_valid <= victim_req;
      if (victim_req)
      begin
        victim_found <= (best_rank != `DCP_RANK_NONE);
        victim_idx <= best_idx;
      end
    end
  end

  // Setting registers; fetch sizes take effect on the next READ, retention codes and last block at once
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wret_reg <= `DCP_RST_CODE;
      rret_reg <= `DCP_RST_CODE;
      scale_reg <= 1'b0;
      dislen_reg <= `DCP_RST_LEN16;
      minpf_reg <= `DCP_RST_LEN16;
      maxpf_reg <= `DCP_RST_LEN16;
      ceil_reg <= `DCP_RST_LEN16;
      lastlba_reg <= `DCP_RST_LASTLBA;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DCP_OFS_CTRL:
        begin
          wret_reg <= reg_wdata[`DCP_CTRL_WRET_LSB +: 4];
          rret_reg <= reg_wdata[`DCP_CTRL_RRET_LSB +: 4];
          scale_reg <= reg_wdata[`DCP_CTRL_SCALE_BIT];
        end
        `DCP_OFS_DISLEN: dislen_reg <= reg_wdata[15:0];
        `DCP_OFS_MINPF: minpf_reg <= reg_wdata[15:0];
        `DCP_OFS_MAXPF: maxpf_reg <= reg_wdata[15:0];
        `DCP_OFS_CEIL: ceil_reg <= reg_wdata[15:0];
        `DCP_OFS_LASTLBA: lastlba_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h00000000;
    else if (!reg_rd)
      reg_rdata <= 32'h00000000;
    else
    begin
      case (reg_addr)
        `DCP_OFS_CTRL: reg_rdata <= {23'h000000, scale_reg, rret_reg, wret_reg};
        `DCP_OFS_DISLEN: reg_rdata <= {16'h0000, dislen_reg};
        `DCP_OFS_MINPF: reg_rdata <= {16'h0000, minpf_reg};
        `DCP_OFS_MAXPF: reg_rdata <= {16'h0000, maxpf_reg};
        `DCP_OFS_CEIL: reg_rdata <= {16'h0000, ceil_reg};
        `DCP_OFS_LASTLBA: reg_rdata <= lastlba_reg;
        `DCP_OFS_STATUS: reg_rdata <= {29'h00000000, superr_reg,
                                       (state_reg == DCP_FETCH), deferred_err};
        `DCP_OFS_FETCHED: reg_rdata <= fetched_reg;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule : dcp_prefetch

// >>> test/dcp_media_model.sv
// Media engine stand-in: acknowledges each block the pre-fetch asks for.
// Assumes pf_req holds until pf_ack; slow sets the idle cycles per block.
`timescale 1ns/100ps
module dcp_media_model (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Fetch handshake
  input wire logic pf_req,
  input wire logic [3:0] slow,
  output logic pf_ack
);
  logic [3:0] wait_reg;

  // One pulse per block; ack is dropped after each pulse so no block is acked twice
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      wait_reg <= 4'h0;
      pf_ack <= 1'b0;
    end
    else if (pf_req && !pf_ack && wait_reg >= slow)
    begin
      wait_reg <= 4'h0;
      pf_ack <= 1'b1;
    end
    else
    begin
      wait_reg <= pf_req ? wait_reg + 4'h1 : 4'h0;
      pf_ack <= 1'b0;
    end
endmodule : dcp_media_model

// >>> test/dcp_prefetch_properties.sv
// Timing checks of the cache policy block, seen from its ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module dcp_prefetch_chk #(
  parameter int LINES = 8,
  parameter int IDXW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic [31:0] cmd_lba,
  input wire logic [15:0] cmd_len,
  input wire logic cmd_pending,
  input wire logic cmd_ready,
  // Media side
  input wire logic pf_req,
  input wire logic [31:0] pf_lba,
  input wire logic pf_ack,
  input wire logic pf_err,
  input wire logic pf_err_fatal,
  input wire logic deferred_err,
  // Replacement choice
  input wire logic victim_req,
  input wire logic [LINES-1:0] line_evictable,
  input wire logic victim_valid,
  input wire logic victim_found,
  input wire logic [IDXW-1:0] victim_idx
);
  logic [LINES-1:0] ev_prev_reg;

  // Line mask of the previous cycle, to judge the chosen index against it
  always_ff @(posedge clock)
    ev_prev_reg <= line_evictable;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // A read command taken, then its fetch raised
  sequence s_take;
    cmd_valid && cmd_ready && cmd_is_read;
  endsequence
  sequence s_begin;
    s_take ##1 pf_req;
  endsequence

  property p_begin_at;
    s_begin |-> pf_lba == $past(cmd_lba) + 32'($past(cmd_len));
  endproperty
  property p_no_write;
    cmd_valid && cmd_ready && !cmd_is_read |=> cmd_ready && !pf_req;
  endproperty
  property p_hold;
    pf_req && !pf_ack && !pf_err && !cmd_pending |=> pf_req && $stable(pf_lba);
  endproperty
  property p_step;
    pf_req && pf_ack |=> !pf_req || pf_lba == $past(pf_lba) + 32'h1;
  endproperty
  property p_fatal;
    pf_req && pf_err && pf_err_fatal |=> !pf_req && deferred_err;
  endproperty
  property p_soft;
    !deferred_err && !pf_err_fatal |=> !deferred_err;
  endproperty
  property p_busy;
    pf_req |-> !cmd_ready;
  endproperty
  property p_vic_pulse;
    victim_req |=> victim_valid;
  endproperty
  property p_vic_none;
    victim_req && line_evictable == '0 |=> !victim_found;
  endproperty
  property p_vic_pick;
    victim_req && |line_evictable |=> victim_found && ev_prev_reg[victim_idx];
  endproperty

  a_begin_at: assert property (p_begin_at) else $error("fetch start block wrong");
  a_no_write: assert property (p_no_write) else $error("fetch after write");
  a_hold: assert property (p_hold) else $error("fetch request not held");
  a_step: assert property (p_step) else $error("fetch block not advanced");
  a_fatal: assert property (p_fatal) else $error("fatal error not handled");
  a_soft: assert property (p_soft) else $error("deferred error without cause");
  a_busy: assert property (p_busy) else $error("ready during fetch");
  a_vic_pulse: assert property (p_vic_pulse) else $error("no victim answer");
  a_vic_none: assert property (p_vic_none) else $error("victim with no line");
  a_vic_pick: assert property (p_vic_pick) else $error("victim not evictable");
endmodule : dcp_prefetch_chk

bind dcp_prefetch dcp_prefetch_chk #(.LINES(LINES), .IDXW(IDXW)) dcp_prefetch_chk_inst (
  .clock, .nrst, .cmd_valid, .cmd_is_read, .cmd_lba, .cmd_len, .cmd_pending, .cmd_ready,
  .pf_req, .pf_lba, .pf_ack, .pf_err, .pf_err_fatal, .deferred_err, .victim_req,
  .line_evictable, .victim_valid, .victim_found, .victim_idx);

// >>> test/tb_top.sv
// Bench of the cache policy block: victim table first, then fetch cases.
// Assumes the media model answers pf_req; the bench drives all else.
`timescale 1ns/100ps
`include "dcp_defs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  typedef struct packed {logic [7:0] code, ev; logic [3:0] idx;} dcp_row_t;
  logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0, cmd_is_read = 0;
  logic cmd_pending = 0, pf_err = 0, pf_err_fatal = 0, victim_req = 0;
  logic cmd_ready, pf_req, pf_ack, deferred_err, victim_valid, victim_found;
  logic [7:0] reg_addr = 8'h00, line_evictable = 8'h00;
  logic [7:0] line_from_read = 8'h02, line_from_write = 8'h04;
  logic [31:0] reg_wdata = 32'h0, cmd_lba = 32'h0, reg_rdata, pf_lba, rv;
  logic [15:0] cmd_len = 16'h0;
  logic [3:0] slow = 4'h0;
  logic [2:0] victim_idx;
  dcp_pkg::dcp_state_t pf_state;
  int err_total = 0, n_compared = 0;
  // Line 0 came by other means, line 1 by a read, line 2 by a write; F means none
  dcp_row_t rows [9] = '{'{8'h00, 8'h07, 4'h0}, '{8'h10, 8'h07, 4'h1},
    '{8'h01, 8'h07, 4'h2}, '{8'hF0, 8'h07, 4'h0}, '{8'hF0, 8'h06, 4'h2},
    '{8'h0F, 8'h06, 4'h1}, '{8'h50, 8'h07, 4'h0}, '{8'h11, 8'h06, 4'h1},
    '{8'h00, 8'h00, 4'hF}};

  dcp_prefetch #(.LINES(8)) dcp_prefetch_inst (.clock, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_is_read, .cmd_lba, .cmd_len,
    .cmd_pending, .cmd_ready, .pf_req, .pf_lba, .pf_ack, .pf_err, .pf_err_fatal,
    .deferred_err, .pf_state, .victim_req, .line_evictable, .line_from_read,
    .line_from_write, .victim_valid, .victim_found, .victim_idx);
  dcp_media_model dcp_media_model_inst (.clock, .nrst, .pf_req, .slow, .pf_ack);

  // Clock of 8 ns
  initial
    forever #4 clock = ~clock;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  task automatic cfg(input logic [31:0] c, d, mn, mx, ce);
    wr(`DCP_OFS_CTRL, c);
    wr(`DCP_OFS_DISLEN, d);
    wr(`DCP_OFS_MINPF, mn);
    wr(`DCP_OFS_MAXPF, mx);
    wr(`DCP_OFS_CEIL, ce);
  endtask : cfg

  // One command; er 1 injects a soft error, 2 a fatal one, early in the fetch
  task automatic run(input logic [31:0] lba, input logic [15:0] len, input logic rdc, go,
                     input logic [1:0] er, input logic [31:0] nf);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_is_read <= rdc;
    cmd_lba <= lba;
    cmd_len <= len;
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1 `CHK("started", go, pf_req)
    `CHK("state", go, pf_state == dcp_pkg::DCP_FETCH)
    if (go)
      `CHK("first block", lba + 32'(len), pf_lba)
    @(posedge clock);
    pf_err <= |er;
    pf_err_fatal <= er[1];
    @(posedge clock);
    pf_err <= 1'b0;
    for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++)
      @(posedge clock);
    #1 `CHK("fetch over", 1'b1, cmd_ready)
    rd(`DCP_OFS_FETCHED);
    if (go)
      `CHK("fetched", nf, rv)
  endtask : run

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wr(`DCP_OFS_CTRL, {24'h0, rows[i].code});
      line_evictable <= rows[i].ev;
      @(posedge clock);
      victim_req <= 1'b1;
      @(posedge clock);
      victim_req <= 1'b0;
      #1 `CHK("found", rows[i].idx != 4'hF, victim_found)
      `CHK("victim valid", 1'b1, victim_valid)
      if (rows[i].idx != 4'hF)
        `CHK("victim", rows[i].idx[2:0], victim_idx)
    end
    // Reset values and a zero threshold, which the table never touches
    rd(`DCP_OFS_LASTLBA);
    `CHK("last block reset", `DCP_RST_LASTLBA, rv)
    rd(8'h40);
    `CHK("unmapped", 32'h0, rv)
    run(32'h0, 16'h0, 1'b1, 1'b0, 2'h0, 32'h0);
    // Medium is large here so the end of medium never cuts a fetch short
    wr(`DCP_OFS_LASTLBA, 32'h3E8);
    cfg(32'h0, 32'h8, 32'h1, 32'h2, 32'hFFFF);
    run(32'hA, 16'h8, 1'b1, 1'b1, 2'h0, 32'h2);
    run(32'hA, 16'h9, 1'b1, 1'b0, 2'h0, 32'h0);
    run(32'hA, 16'h4, 1'b0, 1'b0, 2'h0, 32'h0);
    slow <= 4'h2;
    cfg(32'h0, 32'h8, 32'h1, 32'h5, 32'h3);
    run(32'hA, 16'h4, 1'b1, 1'b1, 2'h0, 32'h3);
    cfg(32'h100, 32'h8, 32'h1, 32'h2, 32'hFFFF);
    run(32'hA, 16'h3, 1'b1, 1'b1, 2'h0, 32'h6);
    cmd_pending <= 1'b1;
    cfg(32'h0, 32'h8, 32'h1, 32'h6, 32'hFFFF);
    run(32'hA, 16'h4, 1'b1, 1'b1, 2'h0, 32'h2);
    cfg(32'h0, 32'h8, 32'h4, 32'h4, 32'hFFFF);
    run(32'hA, 16'h4, 1'b1, 1'b1, 2'h0, 32'h4);
    cmd_pending <= 1'b0;
    wr(`DCP_OFS_LASTLBA, 32'h14);
    cfg(32'h0, 32'h8, 32'h1, 32'h6, 32'hFFFF);
    run(32'hA, 16'h8, 1'b1, 1'b1, 2'h0, 32'h3);
    wr(`DCP_OFS_LASTLBA, 32'h3E8);
    slow <= 4'h3;
    cfg(32'h0, 32'h8, 32'h1, 32'h2, 32'hFFFF);
    run(32'hA, 16'h4, 1'b1, 1'b1, 2'h1, 32'h2);
    rd(`DCP_OFS_STATUS);
    `CHK("soft error", 32'h4, rv & 32'h5)
    run(32'hA, 16'h4, 1'b1, 1'b1, 2'h2, 32'h0);
    `CHK("deferred", 1'b1, deferred_err)
    wr(`DCP_OFS_STATUS, 32'h5);
    rd(`DCP_OFS_STATUS);
    `CHK("status cleared", 32'h0, rv)
    wrap_up();
  end

  // Watchdog, far beyond the few hundred cycles the cases need
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule : tb_top
